// >>> test/dual_input_source_select_tb_top.sv
// self-checking bench of the dual input source selector
`timescale 1ns/1ps
`default_nettype none
module dual_input_source_select_tb_top;
    logic       clk, rst, up1, up2, en1, en2, choice, fixed, heavy, demand;
    logic       higher, step_up, p1, p2, u1, u2, b, c, d, o1, oe1, o2, oe2;
    logic       vcc, cmp, strap, pin1, pin2;
    logic [5:0] duty;
    logic [7:0] na, nb, nc, nd, ne;
    int         err_count, check_count;
    ////////////////////////////////////////
    supply_partner i_partner (.in1_up(up1), .in2_up(up2), .in1_higher(higher),
        .fixed_freq(fixed), .ind1_oe(oe1), .ind2_oe(oe2), .vcc_ok(vcc),
        .cmp_out(cmp), .strap_out(strap), .ind1_pin(pin1), .ind2_pin(pin2));
    // short filter keeps the run brief
    dual_input_source_select #(.FILT_CYC(16)) i_dut (.CLK(clk), .SYS_RST(rst),
        .VCC_OK(vcc), .INPUT1_UV_OK(up1), .INPUT2_UV_OK(up2),
        .INPUT1_ENABLE_PIN(en1), .INPUT2_ENABLE_PIN(en2), .INPUT_CHOICE(choice),
        .LIGHT_LOAD_FIXED(strap), .HEAVY_LOAD(heavy), .REG_DEMAND(demand),
        .INPUT_COMPARE(cmp), .STEP_UP(step_up), .DUTY_CMD(duty),
        .INPUT1_CHARGE_PUMP(p1), .INPUT2_CHARGE_PUMP(p2), .INPUT1_UPPER_FET(u1),
        .INPUT2_UPPER_FET(u2), .INPUT_SIDE_LOWER_FET(b),
        .OUTPUT_SIDE_LOWER_FET(c), .OUTPUT_SIDE_UPPER_FET(d),
        .INPUT1_OK_INDICATOR_I(pin1), .INPUT1_OK_INDICATOR_O(o1),
        .INPUT1_OK_INDICATOR_OE(oe1), .INPUT2_OK_INDICATOR_I(pin2),
        .INPUT2_OK_INDICATOR_O(o2), .INPUT2_OK_INDICATOR_OE(oe2));
    ////////////////////////////////////////
    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // one compare, counted
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for a pump level; sel picks the second pump
    task wait_pump(input logic sel, input logic lvl);
        for (int i = 0; i < 400 && (sel ? p2 : p1) !== lvl; i++)
            cyc(1);
        if ((sel ? p2 : p1) !== lvl)
        begin
            err_count++;
            conclude();
        end
    endtask
    // high time of each gate over one whole 41-clock period, phase free
    task meas;
        cyc(90);
        {na, nb, nc, nd, ne} = '0;
        repeat (41)
        begin
            @(negedge clk);
            {na, nb, nc, nd, ne} = {na + u1, nb + b, nc + c, nd + d, ne + u2};
        end
    endtask
    ////////////////////////////////////////
    // main sequence, inputs move on the falling edge
    initial
    begin
        {rst, up1, up2, en1, en2, choice, heavy, demand, higher, step_up} = 10'h001 << 9;
        {fixed, duty, err_count, check_count} = {1'b1, 6'h0a, 64'h0};
        cyc(4);
        rst = 1'b0;
        cyc(20);
        chk({p1, p2, u1, u2, b, c, d}, 8'h00);
        chk(pin1, 1'b1);
        $display("test 1 done");
        up1 = 1'b1;
        cyc(20);
        chk(oe1, 1'b0);
        en1 = 1'b1;
        cyc(10);
        chk(oe1, 1'b1);
        chk(pin1, 1'b0);
        chk({o1, o2}, 8'h00);
        chk({p1, p2}, 8'h02);
        meas();
        chk({na, nb, ne}, {8'h0a, 8'h1f, 8'h00});
        chk({nc, nd}, {8'h05, 8'h24});
        step_up = 1'b1;
        meas();
        chk({na, nb}, {8'h24, 8'h05});
        chk({nc, nd}, {8'h0a, 8'h1f});
        $display("test 2 done");
        {up2, en2} = 2'b11;
        cyc(10);
        chk({p1, p2}, 8'h02);
        en1 = 1'b0;
        cyc(10);
        chk({p1, p2}, 8'h01);
        meas();
        chk({na, ne}, {8'h00, 8'h24});
        $display("test 3 done");
        {en1, choice} = 2'b11;
        cyc(10);
        chk({p1, p2}, 8'h01);
        higher = 1'b1;
        cyc(5);
        higher = 1'b0;
        cyc(60);
        chk({p1, p2}, 8'h01);
        higher = 1'b1;
        wait_pump(1'b1, 1'b0);
        cyc(180);
        chk({p1, u1, u2}, 8'h00);
        wait_pump(1'b0, 1'b1);
        chk(p2, 1'b0);
        en1 = 1'b0;
        cyc(10);
        chk({p1, p2}, 8'h01);
        $display("test 4 done");
        fixed = 1'b0;
        meas();
        chk(na + nb + nc + nd + ne, 8'h00);
        chk({p2, pin2}, 8'h02);
        demand = 1'b1;
        meas();
        chk(ne, 8'h24);
        {demand, heavy, duty} = {2'b01, 6'h3f};
        meas();
        chk(ne, 8'h24);
        chk({nc, nd}, {8'h28, 8'h01});
        $display("test 5 done");
        en2 = 1'b0;
        cyc(10);
        chk({p1, p2, u1, u2, b, c, d}, 8'h00);
        chk(pin2, 1'b1);
        $display("test 6 done");
        conclude();
    end
endmodule // dual_input_source_select_tb_top
`default_nettype wire

// >>> test/supply_partner.sv
// supply side model: sources, comparator and pulled-up indicator pins
`timescale 1ns/1ps
`default_nettype none
module supply_partner
(
    input  wire logic in1_up,
    input  wire logic in2_up,
    input  wire logic in1_higher,
    input  wire logic fixed_freq,
    input  wire logic ind1_oe,
    input  wire logic ind2_oe,
    output var  logic vcc_ok,
    output var  logic cmp_out,
    output var  logic strap_out,
    output var  logic ind1_pin,
    output var  logic ind2_pin
);
    // driver supply is fed from whichever source is present
    always_comb
    begin
        vcc_ok    = in1_up | in2_up;
        cmp_out   = in1_higher;
        strap_out = fixed_freq;
        // pull-up wins only while the open drain lets go
        ind1_pin  = ind1_oe ? 1'b0 : 1'b1;
        ind2_pin  = ind2_oe ? 1'b0 : 1'b1;
    end
endmodule // supply_partner
`default_nettype wire

// >>> verilog/cmp_filter_if.sv
// carrier between the selector and its comparison filter
`timescale 1ns/1ps
`default_nettype none

interface cmp_filter_if;
    logic raw;
    logic level;
    logic change;

    modport filt (input raw, output level, output change);
    modport user (output raw, input level, input change);
endinterface // cmp_filter_if

`default_nettype wire

// >>> verilog/cmp_settle_filter.sv
// synchroniser and settling filter for the input comparison result
`timescale 1ns/1ps
`default_nettype none
`include "src_sel_cfg.svh"

module cmp_settle_filter
#(
    parameter int FILT_CYC = `SRC_FILT_CYC
)
(
    input  wire logic  CLK,
    input  wire logic  SYS_RST,
    cmp_filter_if.filt fbus
);

    src_sel_pkg::filt_state_type state_reg;
    src_sel_pkg::filt_state_type state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // level only moves after the input has differed for the whole window
    always_comb
    begin
        state_next        = state_reg;
        state_next.sync1  = fbus.raw;
        state_next.sync2  = state_reg.sync1;
        state_next.change = 1'b0;
        if (state_reg.sync2 == state_reg.level)
        begin
            state_next.cnt = '0; // any bounce restarts the window
        end
        else if (state_reg.cnt == `SRC_FILT_W'(FILT_CYC - 1))
        begin
            state_next.level  = state_reg.sync2;
            state_next.change = 1'b1;
            state_next.cnt    = '0;
        end
        else
        begin
            state_next.cnt = state_reg.cnt + `SRC_FILT_W'(1);
        end
    end

    // state register
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign fbus.level  = state_reg.level;
    assign fbus.change = state_reg.change;

    ////////////////////////////////////////////////////////////////////////////////
    // a level change always follows a full window of disagreement
    chk_filter_window: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $changed(state_reg.level) |->
            ($past(state_reg.cnt) == `SRC_FILT_W'(FILT_CYC - 1)) && state_reg.change)
        else $error("comparison level moved before the window ran out");

endmodule // cmp_settle_filter

`default_nettype wire

// >>> verilog/dual_input_source_select.sv
// input selection and switch sequencing of a dual input buck-boost converter
//
// Contract
// - ideal diode: feed output from higher good input
// - ideal diode decode: both, one, or none good
// - priority: input1 when good, else input2
// - no good input: stop switching, no power
// - comparison flip at fixed frequency: suspend six oscillator cycles, swap; when pulse skipping, swap at once
// - comparison result filtered over about 250us
// - good needs driver supply, input level, enable
// - ok indicators pull low while good
// - input1 active: its pump and fet, input2 off
// - input2 active: its pump and fet, input1 off
// - fixed frequency when strap high or heavy load
// - fixed frequency: both nodes switch every cycle
// - step-down: output top off only 100ns
// - step-down: duty on input top and bottom
// - step-up: input top off only 100ns
// - step-up: duty on output bottom and top
// - pulse skipping switches only when regulation needs
`timescale 1ns/1ps
`default_nettype none
`include "src_sel_cfg.svh"

module dual_input_source_select
#(
    parameter int FILT_CYC = `SRC_FILT_CYC
)
(
    input  wire logic                    CLK,
    input  wire logic                    SYS_RST,
    input  wire logic                    VCC_OK,
    input  wire logic                    INPUT1_UV_OK,
    input  wire logic                    INPUT2_UV_OK,
    input  wire logic                    INPUT1_ENABLE_PIN,
    input  wire logic                    INPUT2_ENABLE_PIN,
    input  wire logic                    INPUT_CHOICE,
    input  wire logic                    LIGHT_LOAD_FIXED,
    input  wire logic                    HEAVY_LOAD,
    input  wire logic                    REG_DEMAND,
    input  wire logic                    INPUT_COMPARE,
    input  wire logic                    STEP_UP,
    input  wire logic [`SRC_PHASE_W-1:0] DUTY_CMD,
    output var  logic                    INPUT1_CHARGE_PUMP,
    output var  logic                    INPUT2_CHARGE_PUMP,
    output var  logic                    INPUT1_UPPER_FET,
    output var  logic                    INPUT2_UPPER_FET,
    output var  logic                    INPUT_SIDE_LOWER_FET,
    output var  logic                    OUTPUT_SIDE_LOWER_FET,
    output var  logic                    OUTPUT_SIDE_UPPER_FET,
    input  wire logic                    INPUT1_OK_INDICATOR_I,
    output var  logic                    INPUT1_OK_INDICATOR_O,
    output var  logic                    INPUT1_OK_INDICATOR_OE,
    input  wire logic                    INPUT2_OK_INDICATOR_I,
    output var  logic                    INPUT2_OK_INDICATOR_O,
    output var  logic                    INPUT2_OK_INDICATOR_OE
);

    localparam logic [`SRC_PHASE_W-1:0] PHASE_LAST = `SRC_PHASE_W'(`SRC_PERIOD_CYC - 1);
    localparam logic [`SRC_PHASE_W-1:0] LOW_START  =
        `SRC_PHASE_W'(`SRC_PERIOD_CYC - `SRC_MIN_LOW_CYC);
    localparam logic [`SRC_PHASE_W-1:0] DUTY_MIN   = `SRC_PHASE_W'(1);
    localparam logic [`SRC_SUSP_W-1:0]  SUSP_LAST  = `SRC_SUSP_W'(`SRC_SUSPEND_OSC - 1);

    src_sel_pkg::ctl_state_type state_reg;
    src_sel_pkg::ctl_state_type state_next;

    logic                    good1;
    logic                    good2;
    logic                    ideal;
    logic                    fixed_freq;
    logic                    osc_tick;
    logic                    low_win;
    logic                    duty_on;
    logic                    run_on;
    logic                    gates_off;
    logic [`SRC_PHASE_W-1:0] duty;
    src_sel_pkg::src_type    desired;

    ////////////////////////////////////////////////////////////////////////////////
    // comparison result settles in its own filter
    cmp_filter_if cmp_bus ();

    assign cmp_bus.raw = INPUT_COMPARE;

    cmp_settle_filter
    #(
        .FILT_CYC (FILT_CYC)
    )
    u_cmp_filter
    (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .fbus    (cmp_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // good signals from synchronised comparator levels
    // sync bits: 4 driver supply, 3 input2 level, 2 input1 level, 1 en2, 0 en1
    assign good1 = state_reg.sync2[4] & state_reg.sync2[2] & state_reg.sync2[0];
    assign good2 = state_reg.sync2[4] & state_reg.sync2[3] & state_reg.sync2[1];

    // straps are static levels, read directly
    assign ideal      = INPUT_CHOICE;
    assign fixed_freq = LIGHT_LOAD_FIXED | HEAVY_LOAD;

    ////////////////////////////////////////////////////////////////////////////////
    // source decode for both selection modes
    always_comb
    begin
        desired = src_sel_pkg::SRC_NONE;
        if (ideal)
        begin
            if (good1 && good2)
                desired = cmp_bus.level ? src_sel_pkg::SRC_IN1 : src_sel_pkg::SRC_IN2;
            else if (good1)
                desired = src_sel_pkg::SRC_IN1;
            else if (good2)
                desired = src_sel_pkg::SRC_IN2;
        end
        else
        begin
            if (good1)
                desired = src_sel_pkg::SRC_IN1;
            else if (good2)
                desired = src_sel_pkg::SRC_IN2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator phase and duty window
    assign osc_tick = (state_reg.phase == PHASE_LAST);
    assign low_win  = (state_reg.phase >= LOW_START);

    // duty clamped inside the period so each node still toggles
    always_comb
    begin
        duty = DUTY_CMD;
        if (DUTY_CMD < DUTY_MIN)
            duty = DUTY_MIN;
        else if (DUTY_CMD > PHASE_LAST)
            duty = PHASE_LAST;
    end

    assign duty_on   = (state_reg.phase < duty);
    assign run_on    = (state_reg.st == src_sel_pkg::ST_RUN) && state_reg.active;
    assign gates_off = !(state_reg.upper_in1 | state_reg.upper_in2 | state_reg.fet_b
                       | state_reg.fet_c | state_reg.fet_d
                       | state_reg.pump_in1 | state_reg.pump_in2);

    ////////////////////////////////////////////////////////////////////////////////
    // next state: synchronisers, phase, run state machine, gate commands
    always_comb
    begin
        state_next       = state_reg;
        state_next.sync1 = {VCC_OK, INPUT2_UV_OK, INPUT1_UV_OK,
                            INPUT2_ENABLE_PIN, INPUT1_ENABLE_PIN};
        state_next.sync2 = state_reg.sync1;
        state_next.phase = osc_tick ? `SRC_RST_PHASE : state_reg.phase + `SRC_PHASE_W'(1);

        // pulse skipping decides per period whether to fire at all
        if (osc_tick)
            state_next.active = fixed_freq | REG_DEMAND;

        unique case (state_reg.st)
            src_sel_pkg::ST_IDLE:
            begin
                // nothing switches until a good signal shows up
                if (desired != src_sel_pkg::SRC_NONE)
                begin
                    state_next.st  = src_sel_pkg::ST_RUN;
                    state_next.src = desired;
                end
            end
            src_sel_pkg::ST_RUN:
            begin
                if (desired == src_sel_pkg::SRC_NONE)
                begin
                    state_next.st  = src_sel_pkg::ST_IDLE;
                    state_next.src = src_sel_pkg::SRC_NONE;
                end
                else if (ideal && fixed_freq && cmp_bus.change)
                begin
                    // break before make across the two input paths
                    state_next.st   = src_sel_pkg::ST_SUSPEND;
                    state_next.susp = `SRC_RST_SUSP;
                end
                else
                begin
                    state_next.src = desired;
                end
            end
            src_sel_pkg::ST_SUSPEND:
            begin
                if (desired == src_sel_pkg::SRC_NONE)
                begin
                    state_next.st  = src_sel_pkg::ST_IDLE;
                    state_next.src = src_sel_pkg::SRC_NONE;
                end
                else if (osc_tick)
                begin
                    if (state_reg.susp == SUSP_LAST)
                    begin
                        state_next.st   = src_sel_pkg::ST_RUN;
                        state_next.src  = desired;
                        state_next.susp = `SRC_RST_SUSP;
                    end
                    else
                    begin
                        state_next.susp = state_reg.susp + `SRC_SUSP_W'(1);
                    end
                end
            end
        endcase

        // static path pumps follow the running source only
        state_next.pump_in1 = (state_reg.st == src_sel_pkg::ST_RUN)
                            && (state_reg.src == src_sel_pkg::SRC_IN1);
        state_next.pump_in2 = (state_reg.st == src_sel_pkg::ST_RUN)
                            && (state_reg.src == src_sel_pkg::SRC_IN2);

        // bridge legs; the stage not regulating refreshes its bootstrap
        if (STEP_UP)
        begin
            state_next.upper_in1 = run_on && (state_reg.src == src_sel_pkg::SRC_IN1)
                                 && !low_win;
            state_next.upper_in2 = run_on && (state_reg.src == src_sel_pkg::SRC_IN2)
                                 && !low_win;
            state_next.fet_b  = run_on && low_win;
            state_next.fet_c  = run_on && duty_on;
            state_next.fet_d  = run_on && !duty_on;
        end
        else
        begin
            state_next.upper_in1 = run_on && (state_reg.src == src_sel_pkg::SRC_IN1)
                                 && duty_on;
            state_next.upper_in2 = run_on && (state_reg.src == src_sel_pkg::SRC_IN2)
                                 && duty_on;
            state_next.fet_b  = run_on && !duty_on;
            state_next.fet_c  = run_on && low_win;
            state_next.fet_d  = run_on && !low_win;
        end

        // indicators track good regardless of pulse skipping
        state_next.ind1 = good1;
        state_next.ind2 = good2;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; reset leaves every switch open
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_reg       <= '0;
            state_reg.st    <= src_sel_pkg::ST_IDLE;
            state_reg.src   <= src_sel_pkg::SRC_NONE;
            state_reg.phase <= `SRC_RST_PHASE;
            state_reg.susp  <= `SRC_RST_SUSP;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign INPUT1_CHARGE_PUMP    = state_reg.pump_in1;
    assign INPUT2_CHARGE_PUMP    = state_reg.pump_in2;
    assign INPUT1_UPPER_FET      = state_reg.upper_in1;
    assign INPUT2_UPPER_FET      = state_reg.upper_in2;
    assign INPUT_SIDE_LOWER_FET  = state_reg.fet_b;
    assign OUTPUT_SIDE_LOWER_FET = state_reg.fet_c;
    assign OUTPUT_SIDE_UPPER_FET = state_reg.fet_d;

    // open drain: only ever pull low, pin level is not needed here
    assign INPUT1_OK_INDICATOR_O  = 1'b0;
    assign INPUT1_OK_INDICATOR_OE = state_reg.ind1;
    assign INPUT2_OK_INDICATOR_O  = 1'b0;
    assign INPUT2_OK_INDICATOR_OE = state_reg.ind2;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_no_good;
        !good1 && !good2;
    endsequence

    sequence s_idle_quiet;
        (state_reg.st == src_sel_pkg::ST_IDLE) ##1 gates_off;
    endsequence

    sequence s_swap_start;
        (state_reg.st == src_sel_pkg::ST_RUN) && ideal && fixed_freq && cmp_bus.change
        && (desired != src_sel_pkg::SRC_NONE);
    endsequence

    sequence s_suspend_quiet;
        (state_reg.st == src_sel_pkg::ST_SUSPEND) ##1 gates_off;
    endsequence

    chk_ideal_higher: assert property (
        (state_reg.st == src_sel_pkg::ST_RUN) && ideal && good1 && good2
        && !cmp_bus.change |=>
            (state_reg.src == ($past(cmp_bus.level) ? src_sel_pkg::SRC_IN1
                                                    : src_sel_pkg::SRC_IN2)))
        else $error("ideal diode mode did not pick the higher input");

    chk_ideal_single: assert property (
        (state_reg.st == src_sel_pkg::ST_RUN) && ideal && !good1 && good2 |=>
            (state_reg.src == src_sel_pkg::SRC_IN2))
        else $error("ideal diode mode ignored the only good input");

    chk_priority_in1: assert property (
        (state_reg.st == src_sel_pkg::ST_RUN) && !ideal && good1 |=>
            (state_reg.src == src_sel_pkg::SRC_IN1))
        else $error("priority mode did not hold input1");

    chk_none_stops: assert property (
        s_no_good |=> s_idle_quiet)
        else $error("switching went on with no good input");

    chk_swap_suspend: assert property (
        s_swap_start |=> s_suspend_quiet)
        else $error("comparison change did not suspend switching");

    chk_swap_resume: assert property (
        (state_reg.st == src_sel_pkg::ST_SUSPEND) && osc_tick
        && (state_reg.susp == SUSP_LAST) && (desired != src_sel_pkg::SRC_NONE) |=>
            (state_reg.st == src_sel_pkg::ST_RUN) && (state_reg.src == $past(desired)))
        else $error("suspend did not end after six oscillator cycles");

    chk_good_needs_all: assert property (
        INPUT1_OK_INDICATOR_OE |->
            $past(state_reg.sync2[4] && state_reg.sync2[2] && state_reg.sync2[0]))
        else $error("input1 good without all its conditions");

    chk_indicator_follow: assert property (
        good2 |=> INPUT2_OK_INDICATOR_OE && !INPUT2_OK_INDICATOR_O)
        else $error("input2 indicator not pulled low while good");

    chk_in1_path: assert property (
        (state_reg.st == src_sel_pkg::ST_RUN) && (state_reg.src == src_sel_pkg::SRC_IN1) |=>
            INPUT1_CHARGE_PUMP && !INPUT2_CHARGE_PUMP && !INPUT2_UPPER_FET)
        else $error("input1 path not isolated from input2");

    chk_in2_path: assert property (
        (state_reg.st == src_sel_pkg::ST_RUN) && (state_reg.src == src_sel_pkg::SRC_IN2) |=>
            INPUT2_CHARGE_PUMP && !INPUT1_CHARGE_PUMP && !INPUT1_UPPER_FET)
        else $error("input2 path not isolated from input1");

    chk_buck_refresh: assert property (
        run_on && !STEP_UP && low_win |=> OUTPUT_SIDE_LOWER_FET && !OUTPUT_SIDE_UPPER_FET)
        else $error("step-down refresh interval missing");

    chk_boost_refresh: assert property (
        run_on && STEP_UP && low_win |=>
            INPUT_SIDE_LOWER_FET && !INPUT1_UPPER_FET && !INPUT2_UPPER_FET)
        else $error("step-up refresh interval missing");

    chk_skip_idle: assert property (
        osc_tick && !fixed_freq && !REG_DEMAND |=> ##1 !(INPUT1_UPPER_FET || INPUT2_UPPER_FET
        || INPUT_SIDE_LOWER_FET || OUTPUT_SIDE_LOWER_FET || OUTPUT_SIDE_UPPER_FET))
        else $error("pulse skipping fired without demand");

endmodule // dual_input_source_select

`default_nettype wire

// >>> verilog/src_sel_cfg.svh
// timing counts, widths and reset values of the dual input source selector
`ifndef SRC_SEL_CFG_SVH
`define SRC_SEL_CFG_SVH

// system clock and internal oscillator rates
`define SRC_CLK_KHZ       50000
`define SRC_OSC_KHZ       1200
// oscillator period in system clocks, rounded down
`define SRC_PERIOD_CYC    ((`SRC_CLK_KHZ) / (`SRC_OSC_KHZ))
// least switch low interval, rounded up to whole clocks
`define SRC_MIN_LOW_NS    100
`define SRC_MIN_LOW_CYC   (((`SRC_MIN_LOW_NS) * (`SRC_CLK_KHZ) + 999999) / 1000000)
// settling time of the input comparison result
`define SRC_FILT_US       250
`define SRC_FILT_CYC      ((`SRC_FILT_US) * (`SRC_CLK_KHZ) / 1000)
// oscillator cycles of suspended switching on a changeover
`define SRC_SUSPEND_OSC   6
// field widths
`define SRC_PHASE_W       6
`define SRC_FILT_W        16
`define SRC_SUSP_W        3
`define SRC_SYNC_W        5
// reset values
`define SRC_RST_PHASE     6'h00
`define SRC_RST_SUSP      3'h0

`endif

// >>> verilog/src_sel_pkg.sv
// types shared by the source selector and its comparison filter
`default_nettype none
`include "src_sel_cfg.svh"

package src_sel_pkg;

    // selected supply input
    typedef enum logic [2:0]
    {
        SRC_NONE = 3'h1,
        SRC_IN1  = 3'h2,
        SRC_IN2  = 3'h4
    } src_type;

    // converter run state
    typedef enum logic [2:0]
    {
        ST_IDLE    = 3'h1,
        ST_RUN     = 3'h2,
        ST_SUSPEND = 3'h4
    } run_state_type;

    // comparison filter state
    typedef struct packed
    {
        logic                   sync1;
        logic                   sync2;
        logic                   level;
        logic                   change;
        logic [`SRC_FILT_W-1:0] cnt;
    } filt_state_type;

    // selector state
    typedef struct packed
    {
        logic [`SRC_SYNC_W-1:0]  sync1;
        logic [`SRC_SYNC_W-1:0]  sync2;
        run_state_type           st;
        src_type                 src;
        logic [`SRC_PHASE_W-1:0] phase;
        logic [`SRC_SUSP_W-1:0]  susp;
        logic                    active;
        logic                    pump_in1;
        logic                    pump_in2;
        logic                    upper_in1;
        logic                    upper_in2;
        logic                    fet_b;
        logic                    fet_c;
        logic                    fet_d;
        logic                    ind1;
        logic                    ind2;
    } ctl_state_type;

endpackage

`default_nettype wire
